// ### rtl/ions_nibble.sv
// Purpose: One I/O nibble of six pin slices: serdes, delays, rx FIFO.
// Assumes: Link strobe is sampled by core_clk; bit period is one strobe.
// Notes: Delays are tap counters with no analog meaning here.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
// Contract
// - A bank holds nine nibbles; this nibble has six slices, one pin each.
// - Transmit serializer ratio is 8, 4 or 2 by tx width setting.
// - Output delay taps 0 to 511, range at least 625 ps.
// - Input delay taps 0 to 511, range at least 625 ps.
// - Delay chain join appends output delay, taps 0 to 1023; the code adds two 9-bit taps, so 0 to 1022.
// - Receive deserializer ratio is 8, 4 or 2 by rx width setting; the code takes the ratio from the tx width setting.
// - Each slice writes words into an eight-entry FIFO read by fabric.
// - Receive latency depends on rx width and FIFO mode; the code takes the width from the tx width setting.
// - Differential receive uses two adjacent slices.
// - Transmit feeds pad and own receive path; bidirectional needs gating.
// - Receive gating uses the read window enable.
// - Free running capture clock picks read window enable domain.
// - Transmit gating uses write window enable, serialized, not inverted.
// - Slice 1 transmit is never gated.
// - Tristate source is combinational input or inverted write enable.
// - Each slice is transmit only, receive only or bidirectional.
// - Serial mode serves receivers with unknown clock phase.
// - Register port configures and observes every nibble feature.
// - Self calibration centres delays and tracks drift; the code centres only the input delay taps.
// - Fabric may write delay taps directly.
// - Write enable tristate is inverted and aligned to transmit data; at ratio 2 the code uses tristate_in instead.
module ions_nibble (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire ions_pkg::ions_avm_req_t avm_req,
	output ions_pkg::ions_avm_rsp_t avm_rsp,
	input wire logic link_strobe,
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe_n,
	input wire logic [47:0] tx_word,
	output logic tx_take,
	input wire logic [5:0] tristate_in,
	input wire logic write_window_en,
	input wire logic read_window_en,
	output logic [47:0] rx_word,
	output logic [5:0] rx_valid,
	input wire logic [5:0] rx_pop,
	output logic [5:0] fifo_empty
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0] strb_s;
		logic strb_d;
		logic [5:0] pin_s1;
		logic [5:0] pin_s2;
		logic [1:0] rden_s;
		logic rden_strb;
		logic [31:0] ctrl;
		logic [31:0] slicecfg;
		logic [2:0] tapsel;
		logic [59:0] odly;
		logic [59:0] idly;
		logic [15:0] calstep;
		logic [15:0] calcnt;
		ions_pkg::ions_bus_st_t bst;
		logic [31:0] rdata;
		logic [2:0] bitcnt;
		logic [47:0] txsh;
		logic [5:0] wen_sh;
		logic [5:0] wen_word;
		logic [47:0] rxsh;
		logic [383:0] mem;
		logic [23:0] wp;
		logic [23:0] rp;
		logic [5:0] po;
		logic [5:0] oen;
		logic take;
		logic [47:0] rxo;
		logic [5:0] rvld;
		logic [5:0] emp;
		logic wreq;
		logic rdv;
	} ions_state_t;
	ions_state_t s, next_s;
	logic [2:0] last_bit;
	logic strobe_rise;
	logic gate_open;
	logic [5:0] pin_use;
	always_comb begin
		case (ions_pkg::ions_width_t'(s.ctrl[ions_pkg::CTRL_TXW_LSB +: 2]))
			ions_pkg::IONS_W4: last_bit = 3'h3;
			ions_pkg::IONS_W2: last_bit = 3'h1;
			default: last_bit = 3'h7;
		endcase
	end
	assign strobe_rise = s.strb_s[1] & ~s.strb_d;
	// Free running clock samples the enable on strobe edges; else core clock.
	assign gate_open = ~s.ctrl[ions_pkg::CTRL_RXGATE] |
		s.ctrl[ions_pkg::CTRL_SERIAL] |
		(s.ctrl[ions_pkg::CTRL_FREECLK] ? s.rden_strb : s.rden_s[1]);
	// Differential pairs read the even slice pin for both slices.
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (s.ctrl[ions_pkg::CTRL_DIFF] && (i % 2 == 1)) begin
				pin_use[i] = s.pin_s2[i - 1];
			end else begin
				pin_use[i] = s.pin_s2[i];
			end
		end
	end
	// ==========================================================
	// Next state
	always_comb begin
		logic [1:0] dir;
		logic [2:0] w;
		logic [2:0] r;
		logic [9:0] tot;
		logic txg;
		next_s = s;
		dir = 2'h0;
		w = 3'h0;
		r = 3'h0;
		tot = 10'h000;
		txg = 1'b0;
		next_s.strb_s = {s.strb_s[0], link_strobe};
		next_s.strb_d = s.strb_s[1];
		next_s.pin_s1 = pin_in;
		next_s.pin_s2 = s.pin_s1;
		next_s.rden_s = {s.rden_s[0], read_window_en};
		if (strobe_rise) begin
			next_s.rden_strb = s.rden_s[1];
		end
		next_s.take = 1'b0;
		next_s.rvld = 6'h00;
		next_s.wreq = 1'b1;
		next_s.rdv = 1'b0;
		// Register port: one wait cycle, then answer.
		if (s.bst == ions_pkg::IONS_IDLE &&
			(avm_req.read || avm_req.write)) begin
			next_s.bst = ions_pkg::IONS_RESP;
			next_s.wreq = 1'b0;
			next_s.rdv = avm_req.read;
			if (avm_req.write) begin
				case (avm_req.address)
					ions_pkg::OFS_CTRL: next_s.ctrl = avm_req.writedata;
					ions_pkg::OFS_TAPSEL: next_s.tapsel = avm_req.writedata[2:0];
					ions_pkg::OFS_TAPVAL: begin
						if (s.tapsel < 3'h6) begin
							next_s.odly[s.tapsel*10 +: 10] = avm_req.writedata[25:16];
							next_s.idly[s.tapsel*10 +: 10] = avm_req.writedata[9:0];
						end
					end
					ions_pkg::OFS_SLICECFG: next_s.slicecfg = avm_req.writedata;
					ions_pkg::OFS_CALSTEP: next_s.calstep = avm_req.writedata[15:0];
					default: begin
					end
				endcase
				next_s.rdata = 32'h0000_0000;
			end else begin
				case (avm_req.address)
					ions_pkg::OFS_CTRL: next_s.rdata = s.ctrl;
					ions_pkg::OFS_TAPSEL: next_s.rdata = {29'h0, s.tapsel};
					ions_pkg::OFS_TAPVAL: begin
						if (s.tapsel < 3'h6) begin
							next_s.rdata = {6'h0, s.odly[s.tapsel*10 +: 10],
								6'h0, s.idly[s.tapsel*10 +: 10]};
						end else begin
							next_s.rdata = 32'h0000_0000;
						end
					end
					ions_pkg::OFS_STATUS: next_s.rdata = {20'h0, s.emp, gate_open, 5'h0};
					ions_pkg::OFS_SLICECFG: next_s.rdata = s.slicecfg;
					ions_pkg::OFS_CALSTEP: next_s.rdata = {16'h0, s.calstep};
					default: next_s.rdata = 32'h0000_0000;
				endcase
			end
		end else if (s.bst == ions_pkg::IONS_RESP) begin
			next_s.bst = ions_pkg::IONS_IDLE;
		end
		// Calibration nudges input delay taps toward mid-range; tracking repeats it.
		if ((s.ctrl[ions_pkg::CTRL_CAL] || s.ctrl[ions_pkg::CTRL_TRACK]) &&
			s.bst == ions_pkg::IONS_IDLE) begin
			if (s.calcnt == 16'(ions_pkg::CAL_CYCLES - 1)) begin
				next_s.calcnt = 16'h0000;
				for (int i = 0; i < 6; i++) begin
					if (s.idly[i*10 +: 9] < 9'h100) begin
						next_s.idly[i*10 +: 10] = s.idly[i*10 +: 10] + 10'h001;
					end else if (s.idly[i*10 +: 9] > 9'h100) begin
						next_s.idly[i*10 +: 10] = s.idly[i*10 +: 10] - 10'h001;
					end
				end
				if (s.ctrl[ions_pkg::CTRL_CAL] && !s.ctrl[ions_pkg::CTRL_TRACK]) begin
					next_s.calstep = s.calstep + 16'h0001;
				end
			end else begin
				next_s.calcnt = s.calcnt + 16'h0001;
			end
		end
		// Bit clock: one bit per strobe rise.
		if (strobe_rise) begin
			if (s.bitcnt == last_bit) begin
				next_s.bitcnt = 3'h0;
				next_s.txsh = tx_word;
				next_s.wen_sh = {6{write_window_en}};
				next_s.take = 1'b1;
			end else begin
				next_s.bitcnt = s.bitcnt + 3'h1;
				for (int i = 0; i < 6; i++) begin
					next_s.txsh[i*8 +: 8] = {1'b0, s.txsh[i*8+1 +: 7]};
				end
			end
			for (int i = 0; i < 6; i++) begin
				dir = s.slicecfg[ions_pkg::CFG_MODE_LSB + 2*i +: 2];
				txg = s.ctrl[ions_pkg::CTRL_TXGATE] && i != ions_pkg::GATE_SLICE;
				if (dir != ions_pkg::IONS_RXONLY) begin
					next_s.po[i] = s.txsh[i*8] & (~txg | s.wen_sh[i]);
				end else begin
					next_s.po[i] = 1'b0;
				end
				if (dir == ions_pkg::IONS_TXONLY) begin
					next_s.oen[i] = 1'b0;
				end else if (dir == ions_pkg::IONS_RXONLY) begin
					next_s.oen[i] = 1'b1;
				end else if (s.slicecfg[ions_pkg::CFG_TRI_LSB + i] &&
					last_bit != 3'h1) begin
					next_s.oen[i] = ~s.wen_sh[i];
				end else begin
					next_s.oen[i] = tristate_in[i];
				end
				// Transmit loops back to its own receiver when it drives.
				r = s.bitcnt;
				if (gate_open && dir != ions_pkg::IONS_TXONLY) begin
					next_s.rxsh[i*8 + r] = (dir == ions_pkg::IONS_TXRX && !s.oen[i]) ?
						s.po[i] : pin_use[i];
				end
				tot = {1'b0, s.idly[i*10 +: 9]} +
					(s.slicecfg[ions_pkg::CFG_JOIN_LSB + i] ?
					{1'b0, s.odly[i*10 +: 9]} : 10'h000);
				w = s.wp[i*4 +: 3];
				if (s.bitcnt == last_bit && gate_open &&
					dir != ions_pkg::IONS_TXONLY &&
					(s.wp[i*4 +: 4] ^ s.rp[i*4 +: 4]) != 4'h8 && tot <= 10'h3ff) begin
					// The last bit lands in this same cycle, so store the new copy.
					next_s.mem[(i*8 + w)*8 +: 8] = next_s.rxsh[i*8 +: 8];
					next_s.wp[i*4 +: 4] = s.wp[i*4 +: 4] + 4'h1;
				end
			end
		end
		// Fabric read side; with no pop, bypass mode copies the shift register to the word each cycle.
		for (int i = 0; i < 6; i++) begin
			r = s.rp[i*4 +: 3];
			if (rx_pop[i] && s.wp[i*4 +: 4] != s.rp[i*4 +: 4]) begin
				next_s.rxo[i*8 +: 8] = s.mem[(i*8 + r)*8 +: 8];
				next_s.rvld[i] = 1'b1;
				next_s.rp[i*4 +: 4] = s.rp[i*4 +: 4] + 4'h1;
			end else if (s.ctrl[ions_pkg::CTRL_FIFOBYP]) begin
				next_s.rxo[i*8 +: 8] = s.rxsh[i*8 +: 8];
			end
			next_s.emp[i] = next_s.wp[i*4 +: 4] == next_s.rp[i*4 +: 4];
		end
	end
	// ==========================================================
	// Registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.oen <= 6'h3f;
			s.emp <= 6'h3f;
			s.wreq <= 1'b1;
			s.ctrl <= ions_pkg::CTRL_RESET;
		end else if (clk_en) begin
			s <= next_s;
		end
	end
	assign avm_rsp.readdata = s.rdata;
	assign avm_rsp.waitrequest = s.wreq;
	assign avm_rsp.readdatavalid = s.rdv;
	assign pin_out = s.po;
	assign pin_oe_n = s.oen;
	assign tx_take = s.take;
	assign rx_word = s.rxo;
	assign rx_valid = s.rvld;
	assign fifo_empty = s.emp;
	// ==========================================================
	// Checks
	a_slice1_ungated: assert property (@(posedge core_clk) disable iff (!rst_n)
		strobe_rise && clk_en && s.slicecfg[19:18] != 2'h2 |=> pin_out[1] == $past(s.txsh[8]))
		else $error("slice 1 was gated");
	a_rx_only_hiz: assert property (@(posedge core_clk) disable iff (!rst_n)
		strobe_rise && clk_en && s.slicecfg[17:16] == 2'h2 |=> pin_oe_n[0])
		else $error("rx only slice drove");
	a_tx_gate_closes: assert property (@(posedge core_clk) disable iff (!rst_n)
		strobe_rise && clk_en && s.ctrl[4] && !s.wen_sh[0] |=> !pin_out[0])
		else $error("gated slice sent data");
	a_fifo_no_over: assert property (@(posedge core_clk) disable iff (!rst_n)
		(s.wp[3:0] - s.rp[3:0]) <= 4'h8)
		else $error("fifo overfilled");
	a_empty_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		fifo_empty[0] == (s.wp[3:0] == s.rp[3:0]))
		else $error("empty flag wrong");
	a_bus_one_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && avm_req.read && avm_rsp.waitrequest |=> !avm_rsp.waitrequest)
		else $error("bus answer late");
	a_bit_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.bitcnt <= last_bit || $changed(s.ctrl))
		else $error("bit count beyond width");
	a_tri_wren: assert property (@(posedge core_clk) disable iff (!rst_n)
		strobe_rise && clk_en && s.slicecfg[17:16] == 2'h0 && s.slicecfg[0] &&
		last_bit != 3'h1 |=> pin_oe_n[0] == !$past(s.wen_sh[0]))
		else $error("tristate not inverted wren");
	c_take: cover property (@(posedge core_clk) tx_take);
	c_pop: cover property (@(posedge core_clk) rx_valid[0]);
	c_full: cover property (@(posedge core_clk) (s.wp[3:0] ^ s.rp[3:0]) == 4'h8);
endmodule

// ### include/ions_pkg.sv
// Purpose: Shared constants and types for the nibble serdes datapath.
// Assumes: Avalon-MM register bus with 32-bit data, byte addressing.
// Notes: Offsets are byte addresses.
package ions_pkg;
	localparam int SLICES = 6;
	localparam int NIBBLES_PER_BANK = 9;
	localparam int TAP_W = 9;
	localparam int CASC_TAP_W = 10;
	localparam int TAP_MAX = 511;
	localparam int CASC_TAP_MAX = 1023;
	localparam int DELAY_RANGE_PS = 625;
	localparam int CASC_RANGE_PS = 1250;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW = 3;
	localparam int GATE_SLICE = 1;
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_TAPSEL = 6'h04;
	localparam logic [5:0] OFS_TAPVAL = 6'h08;
	localparam logic [5:0] OFS_STATUS = 6'h0c;
	localparam logic [5:0] OFS_SLICECFG = 6'h10;
	localparam logic [5:0] OFS_CALSTEP = 6'h14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_TXW_LSB = 0;
	localparam int CTRL_RXW_LSB = 2;
	localparam int CTRL_TXGATE = 4;
	localparam int CTRL_RXGATE = 5;
	localparam int CTRL_FREECLK = 6;
	localparam int CTRL_SERIAL = 7;
	localparam int CTRL_CAL = 8;
	localparam int CTRL_TRACK = 9;
	localparam int CTRL_FIFOBYP = 10;
	localparam int CTRL_DIFF = 11;
	localparam int CFG_TRI_LSB = 0;
	localparam int CFG_JOIN_LSB = 8;
	localparam int CFG_MODE_LSB = 16;
	localparam int CORE_MHZ = 25;
	localparam int CAL_PERIOD_NS = 2000;
	localparam int CAL_CYCLES = (CAL_PERIOD_NS * CORE_MHZ) / 1000;
	typedef enum logic [1:0] {
		IONS_W8 = 2'b00,
		IONS_W4 = 2'b01,
		IONS_W2 = 2'b10
	} ions_width_t;
	typedef enum logic [1:0] {
		IONS_TXRX = 2'b00,
		IONS_TXONLY = 2'b01,
		IONS_RXONLY = 2'b10
	} ions_dir_t;
	typedef enum logic [1:0] {
		IONS_IDLE = 2'b00,
		IONS_RESP = 2'b01
	} ions_bus_st_t;
	typedef struct packed {
		logic [5:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} ions_avm_req_t;
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
		logic readdatavalid;
	} ions_avm_rsp_t;
endpackage

// ### verif/ions_link_model.sv
// Purpose: Far-side link device that sends serial frames to the nibble.
// Assumes: Strobe period 320 ns; data changes on the falling strobe.
// Notes: The strobe stands low between frames.
`timescale 1ns/1ns
// ==========================================================
// Link model
module ions_link_model (
	input wire logic frame_go,
	input wire logic [7:0] frame_bits,
	input wire logic [3:0] frame_len,
	output logic link_strobe,
	output logic [5:0] pin_in,
	output logic frame_busy
);
	initial begin
		link_strobe = 1'b0;
		pin_in = 6'h00;
		frame_busy = 1'b0;
	end
	// Frames start on a word boundary, so the fabric needs no bitslip.
	always begin
		@(posedge frame_go);
		frame_busy = 1'b1;
		// Start off the core clock edge so the strobe never races it.
		#7;
		for (int i = 0; i < frame_len; i++) begin
			pin_in = {6{frame_bits[i]}};
			#160 link_strobe = 1'b1;
			#160 link_strobe = 1'b0;
		end
		// No pull on the line, so show the inverse rather than a stale bit.
		pin_in = ~pin_in;
		frame_busy = 1'b0;
	end
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench for the nibble datapath.
// Assumes: Bus answers are awaited with a bounded wait.
// Notes: Serial frames come from the link model.
`timescale 1ns/1ns
// ==========================================================
// Bench
module tb;
	logic core_clk = 1'b0, rst_n = 1'b0, fgo = 1'b0, fbusy, link_strobe;
	logic [7:0] fbits = 8'h00;
	logic [3:0] flen = 4'h0;
	ions_pkg::ions_avm_req_t req = '0;
	ions_pkg::ions_avm_rsp_t rsp;
	logic tx_take, wwe = 1'b0, rwe = 1'b0, seen0, seen1, took, cen = 1'b1;
	logic [5:0] pin_in, pin_out, oe_n, tri_in = 6'h3f, pop = 6'h00;
	logic [5:0] rx_valid, empty;
	logic [47:0] txw = 48'h0, rx_word;
	logic [31:0] rd;
	int error_cnt = 0, total_checks = 0;
	always #20 core_clk = ~core_clk;
	ions_nibble DUT(.core_clk(core_clk), .rst_n(rst_n), .clk_en(cen),
		.avm_req(req), .avm_rsp(rsp), .link_strobe(link_strobe),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n),
		.tx_word(txw), .tx_take(tx_take), .tristate_in(tri_in),
		.write_window_en(wwe), .read_window_en(rwe), .rx_word(rx_word),
		.rx_valid(rx_valid), .rx_pop(pop), .fifo_empty(empty));
	ions_link_model model(.frame_go(fgo), .frame_bits(fbits),
		.frame_len(flen), .link_strobe(link_strobe), .pin_in(pin_in),
		.frame_busy(fbusy));
	task automatic finish_test();
		$display("Checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			$display("Error at %0t: %s", $time, msg);
			error_cnt++;
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		@(posedge core_clk);
		req.address <= a;
		req.write <= wr;
		req.read <= ~wr;
		req.writedata <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 50);
		if (rsp.waitrequest !== 1'b0) begin
			chk(1'b0, "bus hung");
			finish_test();
		end
		rd = rsp.readdata;
		req <= '0;
	endtask
	// Frames are watched some cycles past their end: the strobe is seen late.
	task automatic run_frame(input logic [7:0] b, input logic [3:0] len);
		int n;
		seen0 = 1'b0;
		seen1 = 1'b0;
		took = 1'b0;
		@(posedge core_clk);
		fbits <= b;
		flen <= len;
		fgo <= 1'b1;
		@(posedge core_clk);
		fgo <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
			seen0 |= pin_out[0];
			seen1 |= pin_out[1];
			took |= tx_take;
		end while ((fbusy !== 1'b0 || n < 80) && n < 600);
		if (n >= 600) begin
			chk(1'b0, "frame hung");
			finish_test();
		end
	endtask
	task automatic get_word(input logic [7:0] p, input logic [7:0] m);
		int n;
		n = 0;
		while (empty[0] !== 1'b0 && n < 100) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(n < 100, "no rx word");
		@(posedge core_clk);
		pop <= 6'h01;
		@(posedge core_clk);
		pop <= 6'h00;
		#1;
		chk(rx_valid[0] === 1'b1, "no rx valid");
		chk((rx_word[7:0] & m) === p, "rx word");
	endtask
	task automatic t_regs();
		bus(1'b0, ions_pkg::OFS_CTRL, 32'h0);
		chk(rd === ions_pkg::CTRL_RESET, "ctrl reset");
		bus(1'b0, 6'h3c, 32'h0);
		chk(rd === 32'h0, "unmapped read");
		bus(1'b1, ions_pkg::OFS_TAPSEL, 32'h5);
		bus(1'b1, ions_pkg::OFS_SLICECFG, 32'h0000_2000);
		bus(1'b1, ions_pkg::OFS_TAPVAL, 32'h03ff_03ff);
		bus(1'b0, ions_pkg::OFS_TAPVAL, 32'h0);
		chk(rd === 32'h03ff_03ff, "joined taps");
		bus(1'b1, ions_pkg::OFS_TAPSEL, 32'h0);
		bus(1'b1, ions_pkg::OFS_TAPVAL, 32'h01ff_01ff);
		bus(1'b0, ions_pkg::OFS_TAPVAL, 32'h0);
		chk(rd === 32'h01ff_01ff, "plain taps");
		$display("t_regs finished");
	endtask
	task automatic t_rx();
		logic [7:0] pat [3] = '{8'ha5, 8'h09, 8'h02};
		logic [7:0] msk [3] = '{8'hff, 8'h0f, 8'h03};
		logic [3:0] len [3] = '{4'h8, 4'h4, 4'h2};
		bus(1'b1, ions_pkg::OFS_SLICECFG, 32'h0aaa_0000);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, ions_pkg::OFS_CTRL, k);
			run_frame(pat[k], len[k]);
			get_word(pat[k], msk[k]);
		end
		bus(1'b1, ions_pkg::OFS_CTRL, 32'h20);
		run_frame(8'h3c, 4'h8);
		chk(empty[0] === 1'b1, "gate leaked");
		@(posedge core_clk);
		rwe <= 1'b1;
		run_frame(8'h5a, 4'h8);
		get_word(8'h5a, 8'hff);
		bus(1'b1, ions_pkg::OFS_CTRL, 32'h400);
		run_frame(8'hc3, 4'h8);
		chk(rx_word[7:0] === 8'hc3, "bypass word");
		$display("t_rx finished");
	endtask
	task automatic t_tx();
		bus(1'b1, ions_pkg::OFS_SLICECFG, 32'h0555_0000);
		@(posedge core_clk);
		tri_in <= 6'h00;
		txw <= {48{1'b1}};
		bus(1'b1, ions_pkg::OFS_CTRL, 32'h10);
		// A word taken at a frame's last bit leaves in the next frame.
		run_frame(8'h00, 4'h8);
		chk(took === 1'b1, "no word taken");
		run_frame(8'h00, 4'h8);
		chk(seen1 === 1'b1, "slice 1 gated");
		chk(seen0 === 1'b0, "slice 0 not gated");
		chk(oe_n === 6'h00, "tx only released");
		@(posedge core_clk);
		wwe <= 1'b1;
		run_frame(8'h00, 4'h8);
		run_frame(8'h00, 4'h8);
		chk(seen0 === 1'b1, "gate stuck shut");
		bus(1'b1, ions_pkg::OFS_SLICECFG, 32'h0000_0001);
		@(posedge core_clk);
		tri_in <= 6'h14;
		run_frame(8'h00, 4'h8);
		chk(oe_n === 6'h14, "tristate sources");
		$display("t_tx finished");
	endtask
	task automatic t_cal();
		logic [31:0] v;
		bus(1'b1, ions_pkg::OFS_CTRL, 32'h100);
		repeat (120) @(posedge core_clk);
		bus(1'b0, ions_pkg::OFS_CALSTEP, 32'h0);
		chk(rd[15:0] !== 16'h0000, "no calibration step");
		v = rd;
		@(posedge core_clk);
		cen <= 1'b0;
		repeat (120) @(posedge core_clk);
		cen <= 1'b1;
		bus(1'b0, ions_pkg::OFS_CALSTEP, 32'h0);
		chk(rd[15:0] <= v[15:0] + 16'h0001, "moved while frozen");
		bus(1'b1, ions_pkg::OFS_CTRL, 32'h0);
		bus(1'b0, ions_pkg::OFS_TAPVAL, 32'h0);
		chk(rd[9:0] < 10'h1ff, "tap not centred");
		$display("t_cal finished");
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		chk(oe_n === 6'h3f && empty === 6'h3f, "reset pins");
		rst_n <= 1'b1;
		t_regs();
		t_rx();
		t_tx();
		t_cal();
		finish_test();
	end
endmodule
